// >>> hw/sar_seq_pkg.sv
// Purpose: Shared constants for the serial SAR converter sequencer ends.
// Assumes: One system clock at 40 MHz on both ends.
// Notes: Conversion clock counts are numbered from one.
package sar_seq_pkg;
  localparam int unsigned MCLK_HZ = 40_000_000;
  localparam int unsigned MCLK_PERIOD_NS = 25;
  // Conversion clock period produced by the host end, in ns.
  localparam int unsigned CONV_PERIOD_NS = 300;
  // Half period in system clocks, rounded up, at least one.
  localparam int unsigned HALF_CYC_I =
    (CONV_PERIOD_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [3:0] HALF_CYC =
    (HALF_CYC_I < 1) ? 4'h1 : HALF_CYC_I[3:0];
  localparam int unsigned RES_BITS = 10;
  localparam logic [3:0] CNT_IDLE = 4'h0;
  localparam logic [3:0] CLK_FIRST = 4'h1;
  localparam logic [3:0] CLK_SAMPLE = 4'h3;
  localparam logic [3:0] CLK_MSB = 4'h5;
  localparam logic [3:0] CLK_LAST = 4'hE;
  localparam logic [9:0] RESULT_RST = 10'h000;
endpackage

// >>> hw/sar_link_if.sv
// Purpose: Pin level link between the converter and its host.
// Assumes: Data pin is three-state; host resolves level from data_oe.
// Notes: Host drives clock and start; converter drives data.
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
  logic conv_clk;
  logic start_convert_n;
  logic data_out;
  logic data_oe;
  modport device (
    input conv_clk,
    input start_convert_n,
    output data_out,
    output data_oe
  );
  modport host (
    output conv_clk,
    output start_convert_n,
    input data_out,
    input data_oe
  );
endinterface
`default_nettype wire

// >>> hw/sar_conv_device.sv
// Purpose: Converter end: conversion sequencer and serial result output.
// Assumes: Link pins come from another domain and are synchronised here.
// Notes: A digital sample word stands in for the analog input.
// Notes on behaviour
// R1: Every conversion spans exactly fourteen clock edges.
// R2: Start low seen, next rising edge is clock one.
// R3: Host holds start low one full clock.
// R4: Data driven low from start until MSB.
// R5: Clocks one, two track; sample on clock three.
// R6: Clocks five to fourteen resolve ten bits MSB-first.
// R7: MSB valid at clock five, then one per edge.
// R8: Start high at fifteenth edge: tri-state, idle.
// R9: Synchronized start after clock fourteen falls begins next.
// R10: Prompt restart keeps data low, late restart tri-states.
// R11: Start held low: back-to-back conversions, data low.
// R12: Mode follows only from start timing.
// R13: Host runs clock fourteen per sample, throughout conversion.
// R14: Result coded as straight binary.
// R15: Input tracked until clock three, then ignored.
// R16: Host raises start by clock thirteen for sync mode.
// R17: Three-state data, advanced by conversion clock edges.
// R18: After reset idle with data tri-stated.
`timescale 1ns/1ps
`default_nettype none
module sar_conv_device
  import sar_seq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  sar_link_if.device link,
  input wire logic [RES_BITS-1:0] i_sample,
  output logic [RES_BITS-1:0] o_result,
  output logic o_result_valid,
  output logic o_busy
);

  // Next conversion clock number at a rising edge.
  function automatic logic [3:0] next_count(
    input logic [3:0] cnt,
    input logic start_low
  );
    logic [3:0] n;
    n = cnt;
    if (cnt == CNT_IDLE)
    begin
      n = start_low ? CLK_FIRST : CNT_IDLE;
    end
    else if (cnt == CLK_LAST)
    begin
      n = start_low ? CLK_FIRST : CNT_IDLE;
    end
    else
    begin
      n = cnt + 4'h1;
    end
    return n;
  endfunction

  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_s3_q;
  logic sc_s1_q;
  logic sc_s2_q;
  logic rise;
  logic start_low;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [RES_BITS-1:0] held_q;
  logic [RES_BITS-1:0] approx_q;
  logic [RES_BITS-1:0] approx_d;
  logic bit_d;
  logic [3:0] bit_idx;
  logic [RES_BITS-1:0] trial;
  logic data_q;
  logic oe_q;

  // Both pins come from the host's domain.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      sc_s1_q <= 1'b1;
      sc_s2_q <= 1'b1;
    end
    else
    begin
      clk_s1_q <= link.conv_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      sc_s1_q <= link.start_convert_n;
      sc_s2_q <= sc_s1_q;
    end
  end

  assign rise = clk_s2_q & ~clk_s3_q; // R17
  assign start_low = ~sc_s2_q; // R12

  always_comb
  begin
    cnt_d = next_count(cnt_q, start_low); // R1 R2 R9 R11
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_q <= CNT_IDLE; // R18
    end
    else if (rise)
    begin
      cnt_q <= cnt_d;
    end
  end

  // Input tracks until the sample edge, then is frozen.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      held_q <= RESULT_RST;
    end
    else if (rise && cnt_d == CLK_SAMPLE)
    begin
      held_q <= i_sample; // R5 R15
    end
  end

  // One successive approximation step per edge, MSB at clock five.
  // The bit index only lies inside the word on bit edges five to fourteen.
  always_comb
  begin
    bit_idx = CLK_LAST - cnt_d;
    trial = approx_q;
    bit_d = 1'b0;
    approx_d = approx_q;
    if (cnt_d >= CLK_MSB)
    begin
      trial[bit_idx] = 1'b1;
      bit_d = (trial <= held_q); // R6 R14
      approx_d[bit_idx] = bit_d;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      approx_q <= RESULT_RST;
    end
    else if (rise)
    begin
      if (cnt_d == CLK_FIRST)
      begin
        approx_q <= RESULT_RST;
      end
      else if (cnt_d >= CLK_MSB)
      begin
        approx_q <= approx_d; // R6
      end
    end
  end

  // Serial pin: low from clock one until the MSB edge.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      data_q <= 1'b0;
      oe_q <= 1'b0; // R18
    end
    else if (rise)
    begin
      if (cnt_d == CNT_IDLE)
      begin
        data_q <= 1'b0;
        oe_q <= 1'b0; // R8 R10
      end
      else if (cnt_d >= CLK_MSB)
      begin
        data_q <= bit_d; // R7
        oe_q <= 1'b1;
      end
      else
      begin
        data_q <= 1'b0; // R4 R10 R11
        oe_q <= 1'b1; // R17
      end
    end
  end

  assign link.data_out = data_q;
  assign link.data_oe = oe_q;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_result <= RESULT_RST;
      o_result_valid <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_result_valid <= rise && cnt_d == CLK_LAST;
      if (rise && cnt_d == CLK_LAST)
      begin
        o_result <= approx_d; // R14
      end
      if (rise)
      begin
        o_busy <= (cnt_d != CNT_IDLE);
      end
    end
  end

endmodule // sar_conv_device
`default_nettype wire

// >>> hw/sar_conv_host.sv
// Purpose: Host end: makes the conversion clock, drives start, reads data.
// Assumes: Data pin level arrives from the other domain.
// Notes: The conversion clock runs freely from reset.
`timescale 1ns/1ps
`default_nettype none
module sar_conv_host
  import sar_seq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  sar_link_if.host link,
  input wire logic i_start,
  input wire logic i_free_run,
  output logic [RES_BITS-1:0] o_result,
  output logic o_result_valid,
  output logic o_busy
);

  logic [3:0] div_q;
  logic cclk_q;
  logic fall_ev;
  logic rise_ev;
  logic sc_n_q;
  logic pend_q;
  logic [3:0] cnt_q;
  logic d_s1_q;
  logic d_s2_q;
  logic [RES_BITS-1:0] shift_q;

  assign rise_ev = (div_q == HALF_CYC - 4'h1) && !cclk_q;
  assign fall_ev = (div_q == HALF_CYC - 4'h1) && cclk_q;

  // Clock never stops, so it runs through every conversion.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_q <= 4'h0;
      cclk_q <= 1'b0;
    end
    else if (div_q == HALF_CYC - 4'h1)
    begin
      div_q <= 4'h0;
      cclk_q <= ~cclk_q; // R13
    end
    else
    begin
      div_q <= div_q + 4'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_q <= CNT_IDLE;
    end
    else if (rise_ev)
    begin
      if (cnt_q == CNT_IDLE || cnt_q == CLK_LAST)
      begin
        cnt_q <= sc_n_q ? CNT_IDLE : CLK_FIRST;
      end
      else
      begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // A new request wins over the clear of the pending flag.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pend_q <= 1'b0;
      sc_n_q <= 1'b1;
    end
    else
    begin
      if (i_start)
      begin
        pend_q <= 1'b1;
      end
      else if (fall_ev && !sc_n_q)
      begin
        pend_q <= 1'b0;
      end
      if (fall_ev)
      begin
        if (i_free_run)
        begin
          sc_n_q <= 1'b0;
        end
        else if ((cnt_q == CNT_IDLE || cnt_q == CLK_LAST) && pend_q)
        begin
          sc_n_q <= 1'b0; // R9
        end
        else if (!sc_n_q && cnt_q != CNT_IDLE && cnt_q != CLK_LAST)
        begin
          sc_n_q <= 1'b1; // R3 R16
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      d_s1_q <= 1'b0;
      d_s2_q <= 1'b0;
    end
    else
    begin
      d_s1_q <= link.data_out & link.data_oe;
      d_s2_q <= d_s1_q;
    end
  end

  // Bit shown at edge k is read just before edge k+1.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      shift_q <= RESULT_RST;
      o_result <= RESULT_RST;
      o_result_valid <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_result_valid <= rise_ev && cnt_q == CLK_LAST;
      o_busy <= (cnt_q != CNT_IDLE) || !sc_n_q;
      if (rise_ev && cnt_q >= CLK_MSB)
      begin
        shift_q <= {shift_q[RES_BITS-2:0], d_s2_q};
        if (cnt_q == CLK_LAST)
        begin
          o_result <= {shift_q[RES_BITS-2:0], d_s2_q};
        end
      end
    end
  end

  assign link.conv_clk = cclk_q;
  assign link.start_convert_n = sc_n_q;

endmodule // sar_conv_host
`default_nettype wire

// >>> bench/sar_seq_monitor.sv
// Purpose: Link checker for the converter and host ends.
// Assumes: Link pins are sampled on the system clock.
// Notes: Conversion clock number is tracked from the pins.
`timescale 1ns/1ps
`default_nettype none
module sar_seq_monitor
  import sar_seq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic conv_clk,
  input wire logic start_convert_n,
  input wire logic data_out,
  input wire logic data_oe
);
  logic clk_q;
  logic rise;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [4:0] low_cnt_q;
  logic [3:0] hold_q;
  assign rise = conv_clk && !clk_q;
  // Length of the current start-low pulse and of the current clock level.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      low_cnt_q <= 5'h00;
      hold_q <= 4'h0;
    end
    else
    begin
      if (start_convert_n)
      begin
        low_cnt_q <= 5'h00;
      end
      else if (low_cnt_q != 5'h1F)
      begin
        low_cnt_q <= low_cnt_q + 5'h01;
      end
      if (conv_clk != clk_q)
      begin
        hold_q <= 4'h0;
      end
      else if (hold_q != 4'hF)
      begin
        hold_q <= hold_q + 4'h1;
      end
    end
  end
  always_comb
  begin
    cnt_d = cnt_q;
    if (rise && (cnt_q == 4'h0 || cnt_q == 4'hE))
      cnt_d = start_convert_n ? 4'h0 : 4'h1;
    else if (rise)
      cnt_d = cnt_q + 4'h1;
  end
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      clk_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else
    begin
      clk_q <= conv_clk;
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence conv_end;
    rise && cnt_q == 4'hE;
  endsequence
  start_low_a: assert property (
    rise && cnt_d == 4'h1 |-> ##5 data_oe && !data_out)
    else $error("data not driven low at clock one");
  lead_low_a: assert property (
    rise && cnt_d > 4'h1 && cnt_d < 4'h5 |-> ##5 data_oe && !data_out)
    else $error("data not low before first bit");
  drive_conv_a: assert property (
    rise && cnt_d > 4'h4 |-> ##5 data_oe)
    else $error("data not driven during bits");
  single_end_a: assert property (
    conv_end ##0 start_convert_n |-> ##5 !data_oe)
    else $error("data not released after conversion");
  free_run_a: assert property (
    conv_end ##0 !start_convert_n |-> ##5 data_oe && !data_out)
    else $error("data not low between conversions");
  idle_float_a: assert property (
    rise && cnt_d == 4'h0 |-> ##5 !data_oe)
    else $error("data driven while idle");
  oe_timing_a: assert property (
    $changed(data_oe) |-> $past(rise, 2) || $past(rise, 3) || $past(rise, 4))
    else $error("enable moved away from clock edge");
  bit_timing_a: assert property (
    $changed(data_out) |-> $past(rise, 2) || $past(rise, 3) || $past(rise, 4))
    else $error("data moved away from clock edge");
  start_width_a: assert property (
    $rose(start_convert_n) |-> low_cnt_q >= 2 * HALF_CYC)
    else $error("start low shorter than one clock");
  clock_runs_a: assert property (
    cnt_q != 4'h0 |-> hold_q < HALF_CYC)
    else $error("clock stalled during conversion");
endmodule // sar_seq_monitor
`default_nettype wire

// >>> bench/test_serial_sar_adc_sequencer.sv
// Purpose: Self-checking bench for both converter link ends.
// Assumes: Sample word stands in for the analog input.
// Notes: Single-shot results are judged on both user sides; later tests judge the host side.
`timescale 1ns/1ps
`default_nettype none
module test_serial_sar_adc_sequencer;
  import sar_seq_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_start = 1'b0;
  logic i_free_run = 1'b0;
  logic [RES_BITS-1:0] i_sample = 10'h000;
  logic [RES_BITS-1:0] h_res;
  logic [RES_BITS-1:0] d_res;
  logic h_val;
  logic d_val;
  logic d_busy;
  logic h_busy;
  int fail_count = 0;
  int compares = 0;
  int n;
  int d_seen = 0;
  localparam int CONV_MCLK = int'(CLK_LAST) * 2 * int'(HALF_CYC);
  sar_link_if u_link ();
  sar_conv_device i_sar_conv_device (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .link(u_link.device), .i_sample(i_sample), .o_result(d_res),
    .o_result_valid(d_val), .o_busy(d_busy));
  sar_conv_host i_sar_conv_host (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .link(u_link.host), .i_start(i_start), .i_free_run(i_free_run),
    .o_result(h_res), .o_result_valid(h_val), .o_busy(h_busy));
  sar_seq_monitor u_mon (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .conv_clk(u_link.conv_clk), .start_convert_n(u_link.start_convert_n),
    .data_out(u_link.data_out), .data_oe(u_link.data_oe));
  always #12.5 i_mclk = ~i_mclk;
  // Counts device result pulses, seen where they are settled.
  always @(negedge i_mclk)
  begin
    if (d_val === 1'b1)
      d_seen++;
  end
  task automatic print_verdict();
  begin
    $display("Checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task automatic chk_word(input logic [RES_BITS-1:0] got, exp);
  begin
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: word %h, want %h", $time, got, exp);
    end
  end
  endtask
  task automatic chk_flag(input logic got, exp);
  begin
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: flag %b, want %b", $time, got, exp);
    end
  end
  endtask
  // Counts system clocks up to the next host result pulse.
  task automatic wait_valid();
  begin
    n = 0;
    do
    begin
      @(negedge i_mclk);
      n++;
    end
    while (h_val !== 1'b1 && n < 600);
    if (h_val !== 1'b1)
    begin
      fail_count++;
      $display("Error %0t: no result", $time);
      print_verdict();
    end
  end
  endtask
  task automatic req();
  begin
    i_start = 1'b1;
    @(negedge i_mclk);
    i_start = 1'b0;
  end
  endtask
  task automatic single_shot();
    logic [RES_BITS-1:0] v [3] = '{10'h000, 10'h3FF, 10'h2A5};
  begin
    foreach (v[k])
    begin
      i_sample = v[k];
      req();
      wait_valid();
      chk_word(h_res, v[k]);
      chk_word(d_res, v[k]);
      chk_flag(d_seen == k + 1, 1'b1);
      repeat (6) @(negedge i_mclk);
      chk_flag(u_link.data_oe, 1'b0);
      chk_flag(d_busy, 1'b0);
      chk_flag(h_busy, 1'b0);
    end
  end
  endtask
  task automatic late_change();
  begin
    i_sample = 10'h155;
    req();
    repeat (80) @(negedge i_mclk);
    chk_flag(d_busy, 1'b1);
    chk_flag(h_busy, 1'b1);
    i_sample = 10'h2AA;
    wait_valid();
    chk_word(h_res, 10'h155);
  end
  endtask
  task automatic sync_mode();
  begin
    i_sample = 10'h0F0;
    req();
    repeat (100) @(negedge i_mclk);
    chk_flag(u_link.start_convert_n, 1'b1);
    req();
    i_sample = 10'h30F;
    wait_valid();
    chk_word(h_res, 10'h0F0);
    wait_valid();
    chk_word(h_res, 10'h30F);
    chk_flag(n == CONV_MCLK, 1'b1);
  end
  endtask
  task automatic free_run();
  begin
    i_sample = 10'h001;
    i_free_run = 1'b1;
    wait_valid();
    chk_word(h_res, 10'h001);
    i_sample = 10'h200;
    wait_valid();
    chk_word(h_res, 10'h200);
    chk_flag(n == CONV_MCLK, 1'b1);
    chk_flag(u_link.data_oe, 1'b1);
    i_free_run = 1'b0;
    wait_valid();
    repeat (6) @(negedge i_mclk);
    chk_flag(u_link.data_oe, 1'b0);
  end
  endtask
  initial
  begin
    repeat (4) @(negedge i_mclk);
    i_rstn = 1'b1;
    repeat (30) @(negedge i_mclk);
    chk_flag(u_link.data_oe, 1'b0);
    single_shot();
    late_change();
    sync_mode();
    free_run();
    print_verdict();
  end
endmodule // test_serial_sar_adc_sequencer
`default_nettype wire
